// ---- core/pld_config_regs.sv ----
// serial-written lock detect, modulator and analog enable configuration registers
`timescale 1ns/10ps
module pld_config_regs
	import pld_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        sclk_i,
	input  wire logic        sen_i,
	input  wire logic        sdi_i,
	input  wire logic [2:0]  chip_addr_i,
	input  wire logic        ext_vco_sel_i,
	input  wire logic        pd_tick_i,
	input  wire logic        in_window_i,
	input  wire logic        phase_err_large_i,
	output logic             lock_serial_out_pin_o,
	output logic             lock_serial_out_pin_oe_o,
	output logic             sdo_level_3v_o,
	output logic [23:0]      frac_value_o,
	output logic             frac_load_o,
	output logic             seed_load_o,
	output logic             mod_enable_o,
	output logic             locked_o,
	output logic             training_o,
	output logic             cp_boost_o,
	output logic             bias_enable_o,
	output logic             hf_ref_o
);
	// pin synchronisers and filtered levels
	logic [2:0]  sclk_s, sen_s, sdi_s;
	logic        sclk_f, sen_f, sdi_f;
	logic        sclk_rise, sclk_fall, sen_rise, sen_fall;
	// frame shifter
	logic [31:0] shift_r;
	logic [5:0]  bit_cnt_r;
	logic        hdr_seen_r;
	logic        rd_act_r;
	logic [23:0] rd_sh_r;
	logic [23:0] rd_data;
	pld_frame_t  frm;
	logic        wr_ok;
	// registers
	logic [2:0]  chip_r;
	logic        strap_done_r;
	logic [23:0] frac_r;
	logic [23:0] mod_r;
	pld_lkd_t    lkd_r;
	pld_aen_t    aen_r;
	logic [23:0] sdo_cfg_r;
	logic        train_pulse_r;
	logic        oe_nxt;
	logic        first_r;

	// three stages per pin; a level counts once stages two and three agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_s <= 3'h0;
			sen_s  <= 3'h0;
			sdi_s  <= 3'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk_i};
			sen_s  <= {sen_s[1:0], sen_i};
			sdi_s  <= {sdi_s[1:0], sdi_i};
		end
	end

	// filtered levels move only on agreement, rejecting single-sample glitches
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_f <= 1'b0;
			sen_f  <= 1'b0;
			sdi_f  <= 1'b0;
		end else begin
			if (sclk_s[1] == sclk_s[2]) sclk_f <= sclk_s[2];
			if (sen_s[1] == sen_s[2])   sen_f  <= sen_s[2];
			if (sdi_s[1] == sdi_s[2])   sdi_f  <= sdi_s[2];
		end
	end

	// edge events of the filtered link clock and enable
	assign sclk_rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_f;
	assign sclk_fall = (sclk_s[1] == sclk_s[2]) && !sclk_s[2] && sclk_f;
	assign sen_rise  = (sen_s[1] == sen_s[2]) && sen_s[2] && !sen_f;
	assign sen_fall  = (sen_s[1] == sen_s[2]) && !sen_s[2] && sen_f;

	// chip address strap caught once after reset release
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chip_r       <= RST_CHIP;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			chip_r       <= chip_addr_i;
			strap_done_r <= 1'b1;
		end
	end

	// shift sdi in on rising sclk, msb first, while enable is high
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_r   <= 32'h00000000;
			bit_cnt_r <= 6'h00;
		end else if (sen_rise) begin
			bit_cnt_r <= 6'h00;
		end else if (sen_f && sclk_rise) begin
			shift_r <= {shift_r[30:0], sdi_f};
			if (bit_cnt_r != 6'h3f) begin
				bit_cnt_r <= bit_cnt_r + 6'h01;
			end
		end
	end

	// a write commits only on a whole frame for this chip; short or long frames drop
	assign frm   = pld_frame_t'(shift_r);
	assign wr_ok = sen_fall && (bit_cnt_r == 6'(FRAME_W)) && !frm.rd && (frm.chip == chip_r);

	// register file; reserved fields store what the host writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frac_r    <= RST_FRAC;
			mod_r     <= RST_MOD;
			lkd_r     <= RST_LKD;
			aen_r     <= RST_AEN;
			sdo_cfg_r <= RST_SDO_CFG;
		end else if (wr_ok) begin
			case (frm.addr)
				OFS_FRAC:    frac_r    <= frm.data;
				OFS_MOD:     mod_r     <= frm.data;
				OFS_LKD:     lkd_r     <= frm.data;
				OFS_AEN:     aen_r     <= frm.data;
				OFS_SDO_CFG: sdo_cfg_r <= frm.data;
				default:     ;
			endcase
		end
	end

	// readback mux; unmapped offsets read zero
	always_comb begin
		case (shift_r[3:0])
			OFS_FRAC:    rd_data = frac_r;
			OFS_MOD:     rd_data = mod_r;
			OFS_LKD:     rd_data = lkd_r;
			OFS_AEN:     rd_data = aen_r;
			OFS_SDO_CFG: rd_data = sdo_cfg_r;
			default:     rd_data = 24'h000000;
		endcase
	end

	// header done: every header loads the data shifter; a read for this chip activates it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hdr_seen_r <= 1'b0;
			rd_act_r   <= 1'b0;
			rd_sh_r    <= 24'h000000;
		end else if (sen_rise || sen_fall) begin
			hdr_seen_r <= 1'b0;
			rd_act_r   <= 1'b0;
		end else if (sen_f && !hdr_seen_r && bit_cnt_r == 6'(HDR_W)) begin
			hdr_seen_r <= 1'b1;
			rd_act_r   <= shift_r[7] && (shift_r[6:4] == chip_r);
			rd_sh_r    <= rd_data;
		end else if (rd_act_r && sclk_fall) begin
			rd_sh_r <= {rd_sh_r[22:0], 1'b0};
		end
	end

	// serial output: read data during a read, lock status otherwise
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_serial_out_pin_o <= 1'b0;
		end else if (rd_act_r) begin
			if (sclk_fall) lock_serial_out_pin_o <= rd_sh_r[23];
		end else begin
			lock_serial_out_pin_o <= locked_o;
		end
	end

	// driver enable; the zero-address exception lets one part own a shared bus
	always_comb begin
		if (!aen_r.out_pin_en) begin
			oe_nxt = 1'b0;
		end else if (sdo_cfg_r[BIT_SDO_DRIVE]) begin
			oe_nxt = 1'b1;
		end else begin
			// stay off until the strap is caught, never drive on a guessed address
			oe_nxt = strap_done_r && (chip_r == SHARED_CHIP);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_serial_out_pin_oe_o <= 1'b0;
		end else begin
			lock_serial_out_pin_oe_o <= oe_nxt;
		end
	end

	// fractional write strobes; seed reload only with autoseed set
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frac_load_o <= 1'b0;
			seed_load_o <= 1'b0;
		end else begin
			frac_load_o <= wr_ok && (frm.addr == OFS_FRAC);
			seed_load_o <= wr_ok && (frm.addr == OFS_FRAC) && mod_r[BIT_AUTOSEED];
		end
	end

	assign frac_value_o = frac_r;

	// training fires on a written 0-to-1 only, so rewriting 1 is harmless
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			train_pulse_r <= 1'b0;
		end else begin
			train_pulse_r <= wr_ok && (frm.addr == OFS_LKD) && frm.data[20] && !lkd_r.train;
		end
	end

	// slip boost holds to the end of the comparison cycle; a new excess wins over the end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cp_boost_o <= 1'b0;
		end else if (!lkd_r.slip_prev_en) begin
			cp_boost_o <= 1'b0;
		end else if (phase_err_large_i) begin
			cp_boost_o <= 1'b1;
		end else if (pd_tick_i) begin
			cp_boost_o <= 1'b0;
		end
	end

	// static analog controls, registered to keep outputs glitch free
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mod_enable_o   <= 1'b0;
			bias_enable_o  <= 1'b0;
			hf_ref_o       <= 1'b0;
			sdo_level_3v_o <= 1'b0;
		end else begin
			mod_enable_o   <= mod_r[BIT_MOD_EN];
			bias_enable_o  <= aen_r.bias_en && ext_vco_sel_i;
			hf_ref_o       <= aen_r.hf_ref;
			sdo_level_3v_o <= aen_r.sdo_lvl_3v;
		end
	end

	pld_lock_det u_lock_det (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.enable_i    (lkd_r.det_en),
		.train_i     (train_pulse_r),
		.wincnt_i    (lkd_r.wincnt),
		.pd_tick_i   (pd_tick_i),
		.in_window_i (in_window_i),
		.locked_o    (locked_o),
		.training_o  (training_o)
	);

	// marks the first cycle after release for reset value checks
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) first_r <= 1'b1;
		else          first_r <= 1'b0;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_SEED_ON_FRAC: assert property (wr_ok && frm.addr == OFS_FRAC && mod_r[BIT_AUTOSEED] |=> seed_load_o)
		else $error("fractional write missed seed reload");
	AST_NO_SEED: assert property (wr_ok && frm.addr == OFS_FRAC && !mod_r[BIT_AUTOSEED]
		|=> frac_load_o && !seed_load_o)
		else $error("seed reloaded with autoseed clear");
	AST_MOD_EN_FOLLOWS: assert property (wr_ok && frm.addr == OFS_MOD
		|=> ##1 mod_enable_o == $past(frm.data[BIT_MOD_EN], 2))
		else $error("modulator enable did not follow write");
	AST_TRAIN_EDGE: assert property (wr_ok && frm.addr == OFS_LKD
		|=> train_pulse_r == ($past(frm.data[20]) && !$past(lkd_r.train)))
		else $error("training trigger not on rising write");
	AST_SLIP_BOOST: assert property (lkd_r.slip_prev_en && phase_err_large_i |=> cp_boost_o)
		else $error("slip prevention boost missing");
	AST_SLIP_OFF: assert property (!lkd_r.slip_prev_en |=> !cp_boost_o)
		else $error("boost while slip prevention disabled");
	AST_SDO_OFF: assert property (!aen_r.out_pin_en |=> !lock_serial_out_pin_oe_o)
		else $error("serial output driven with enable clear");
	AST_SDO_DRIVE: assert property (aen_r.out_pin_en && sdo_cfg_r[BIT_SDO_DRIVE] |=> lock_serial_out_pin_oe_o)
		else $error("serial output not driven continuously");
	AST_SDO_SHARE: assert property (aen_r.out_pin_en && !sdo_cfg_r[BIT_SDO_DRIVE] && strap_done_r
		|=> lock_serial_out_pin_oe_o == (chip_r == SHARED_CHIP))
		else $error("shared bus driver state wrong");
	AST_RESET_VALUES: assert property (first_r |-> lkd_r == RST_LKD && aen_r == RST_AEN)
		else $error("register reset value wrong");
	AST_BIAS_EXT_ONLY: assert property (!ext_vco_sel_i |=> !bias_enable_o)
		else $error("bias enabled without external oscillator");
	COV_SEEDED_WRITE: cover property (seed_load_o);
	COV_READ_FRAME: cover property (rd_act_r ##1 sclk_fall);
	COV_TRAIN: cover property (train_pulse_r);
	COV_BOOST: cover property ($rose(cp_boost_o));
endmodule : pld_config_regs

// ---- core/pld_lock_det.sv ----
// consecutive in-window counter that declares and drops lock
`timescale 1ns/10ps
module pld_lock_det
	import pld_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       enable_i,
	input  wire logic       train_i,
	input  wire logic [2:0] wincnt_i,
	input  wire logic       pd_tick_i,
	input  wire logic       in_window_i,
	output logic            locked_o,
	output logic            training_o
);
	logic [15:0] cnt_r;
	logic [15:0] target;
	logic        count_en;

	assign target   = pld_win_target(wincnt_i);
	// counting pauses while a retraining waits for its comparison cycle
	assign count_en = pd_tick_i && enable_i && !training_o && !train_i;

	// retraining holds off counting until the next comparison edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			training_o <= 1'b0;
		end else if (train_i) begin
			training_o <= 1'b1;
		end else if (pd_tick_i) begin
			training_o <= 1'b0;
		end
	end

	// consecutive count; any miss restarts from zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r    <= 16'h0000;
			locked_o <= 1'b0;
		end else if (!enable_i || train_i) begin
			cnt_r    <= 16'h0000;
			locked_o <= 1'b0;
		end else if (count_en) begin
			if (in_window_i) begin
				if (cnt_r < target) begin
					cnt_r <= cnt_r + 16'h0001;
				end
				locked_o <= (cnt_r + 16'h0001 >= target) || locked_o;
			end else begin
				cnt_r    <= 16'h0000;
				locked_o <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_LD_DISABLED_NO_LOCK: assert property (!enable_i |=> !locked_o && cnt_r == 16'h0000)
		else $error("lock reported while detector disabled");
	AST_MISS_DROPS_LOCK: assert property (count_en && !in_window_i |=> !locked_o && cnt_r == 16'h0000)
		else $error("out of window count did not drop lock");
	AST_LOCK_AT_TARGET: assert property (count_en && in_window_i && cnt_r == target - 16'h0001 |=> locked_o)
		else $error("lock not declared at window target");
	AST_NO_EARLY_LOCK: assert property (!locked_o && !(count_en && in_window_i && cnt_r + 16'h0001 >= target)
		|=> !locked_o)
		else $error("lock declared before window target");
	AST_TRAIN_RESTARTS: assert property (train_i |=> training_o && !locked_o ##1 !locked_o)
		else $error("training did not restart lock detector");
	COV_LOCK_REACHED: cover property ($rose(locked_o));
endmodule : pld_lock_det

// ---- core/pld_pkg.sv ----
// shared constants, register layout and frame types for the lock detect configuration slice
package pld_pkg;
	// serial frame geometry
	localparam int          REG_W         = 24;
	localparam int          FRAME_W       = 32;
	localparam int          HDR_W         = 8;
	// register offsets
	localparam logic [3:0]  OFS_FRAC      = 4'h4;
	localparam logic [3:0]  OFS_MOD       = 4'h6;
	localparam logic [3:0]  OFS_LKD       = 4'h7;
	localparam logic [3:0]  OFS_AEN       = 4'h8;
	localparam logic [3:0]  OFS_SDO_CFG   = 4'hf;
	// reset values
	localparam logic [23:0] RST_FRAC      = 24'h000000;
	localparam logic [23:0] RST_MOD       = 24'h030f0a;
	localparam logic [23:0] RST_LKD       = 24'h200844;
	localparam logic [23:0] RST_AEN       = 24'h01bfff;
	localparam logic [23:0] RST_SDO_CFG   = 24'h000000;
	localparam logic [2:0]  RST_CHIP      = 3'h0;
	// field positions outside the structs
	localparam int          BIT_AUTOSEED  = 8;
	localparam int          BIT_MOD_EN    = 11;
	localparam int          BIT_SDO_DRIVE = 7;
	// chip address that may keep the serial output on a shared bus
	localparam logic [2:0]  SHARED_CHIP   = 3'h0;
	// consecutive in-window counts per window code
	localparam logic [15:0] WIN_CNT_0     = 16'h0005;
	localparam logic [15:0] WIN_CNT_1     = 16'h0020;
	localparam logic [15:0] WIN_CNT_2     = 16'h0060;
	localparam logic [15:0] WIN_CNT_3     = 16'h0100;
	localparam logic [15:0] WIN_CNT_4     = 16'h0200;
	localparam logic [15:0] WIN_CNT_5     = 16'h0800;
	localparam logic [15:0] WIN_CNT_6     = 16'h2000;
	localparam logic [15:0] WIN_CNT_7     = 16'hffff;

	typedef struct packed {
		logic [1:0] rsv_hi;
		logic       slip_prev_en;
		logic       train;
		logic [7:0] rsv_mid;
		logic       det_en;
		logic [7:0] rsv_lo;
		logic [2:0] wincnt;
	} pld_lkd_t;

	typedef struct packed {
		logic       rsv_top;
		logic       sdo_lvl_3v;
		logic       hf_ref;
		logic [9:0] rsv_hi;
		logic       bias_en;
		logic [3:0] rsv_mid;
		logic       out_pin_en;
		logic [4:0] rsv_lo;
	} pld_aen_t;

	typedef struct packed {
		logic        rd;
		logic [2:0]  chip;
		logic [3:0]  addr;
		logic [23:0] data;
	} pld_frame_t;

	// window code to required consecutive count
	function automatic logic [15:0] pld_win_target(input logic [2:0] code);
		case (code)
			3'h0:    pld_win_target = WIN_CNT_0;
			3'h1:    pld_win_target = WIN_CNT_1;
			3'h2:    pld_win_target = WIN_CNT_2;
			3'h3:    pld_win_target = WIN_CNT_3;
			3'h4:    pld_win_target = WIN_CNT_4;
			3'h5:    pld_win_target = WIN_CNT_5;
			3'h6:    pld_win_target = WIN_CNT_6;
			default: pld_win_target = WIN_CNT_7;
		endcase
	endfunction : pld_win_target
endpackage : pld_pkg

// ---- tb/pld_config_regs_bench.sv ----
// self-checking bench for the lock detect configuration slice
`timescale 1ns/10ps
module pld_config_regs_bench
	import pld_pkg::*;
;
	typedef struct packed {
		logic [3:0]  what;
		logic [23:0] exp;
	} pld_note_t;
	localparam logic [3:0] W_RD = 4'h0, W_FRAC = 4'h1, W_NF = 4'h2, W_NS = 4'h3, W_OE = 4'h4, W_LVL = 4'h5;
	localparam logic [3:0] W_MOD = 4'h6, W_LCK = 4'h7, W_TRN = 4'h8, W_SLIP = 4'h9, W_BIAS = 4'ha, W_HF = 4'hb;
	// reference crystal frequency seen by the host
	localparam int REF_MHZ = 250;

	logic        clk, rst_n, sclk, sen, sdi, ext_vco_sel, pd_tick, in_window, phase_err;
	logic        sdo, sdo_oe, lvl3v, frac_load, seed_load, mod_en, locked, training, boost, bias, hf_ref;
	logic [2:0]  chip_addr, chip_s;
	logic [23:0] frac_value, rd_r, f;
	logic [15:0] targ [6];
	int          n_mismatch, compares, n_frac, n_seed, e_frac, e_seed;
	pld_note_t   notes[$];
	event        chk_ev;

	pld_config_regs u_pld_config_regs (
		.clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .sen_i(sen), .sdi_i(sdi),
		.chip_addr_i(chip_addr), .ext_vco_sel_i(ext_vco_sel), .pd_tick_i(pd_tick),
		.in_window_i(in_window), .phase_err_large_i(phase_err),
		.lock_serial_out_pin_o(sdo), .lock_serial_out_pin_oe_o(sdo_oe), .sdo_level_3v_o(lvl3v),
		.frac_value_o(frac_value), .frac_load_o(frac_load), .seed_load_o(seed_load),
		.mod_enable_o(mod_en), .locked_o(locked), .training_o(training), .cp_boost_o(boost),
		.bias_enable_o(bias), .hf_ref_o(hf_ref)
	);
	pld_host_model u_pld_host_model (
		.sclk_o(sclk), .sen_o(sen), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// pulses counted per cycle, so a stretched pulse shows as an extra count
	always @(posedge clk) begin
		if (frac_load === 1'b1) n_frac++;
		if (seed_load === 1'b1) n_seed++;
	end

	function automatic logic [23:0] observe(input logic [3:0] w);
		case (w)
			W_RD:    return rd_r;
			W_FRAC:  return frac_value;
			W_NF:    return 24'(n_frac);
			W_NS:    return 24'(n_seed);
			W_OE:    return {23'h0, sdo_oe};
			W_LVL:   return {23'h0, lvl3v};
			W_MOD:   return {23'h0, mod_en};
			W_LCK:   return {23'h0, locked};
			W_TRN:   return {23'h0, training};
			W_SLIP:  return {23'h0, boost};
			W_HF:    return {23'h0, hf_ref};
			default: return {23'h0, bias};
		endcase
	endfunction : observe

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// monitor drains every queued note, oldest first, whenever a result is presented
	initial forever begin
		@(chk_ev);
		while (notes.size() > 0) begin
			check(observe(notes[0].what), notes[0].exp);
			void'(notes.pop_front());
		end
	end

	// settle past the edge before presenting the result
	task automatic note_exp(input logic [3:0] w, input logic [23:0] e);
		#1;
		notes.push_back('{w, e});
		-> chk_ev;
	endtask : note_exp

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		logic [23:0] unused;
		u_pld_host_model.frame({1'b0, chip_s, a, d}, unused);
		cyc(10);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [23:0] e);
		logic [23:0] d;
		u_pld_host_model.frame({1'b1, chip_s, a, 24'h0}, d);
		rd_r = d;
		note_exp(W_RD, e);
		cyc(2);
	endtask : rd

	task automatic tick(input logic win);
		@(posedge clk);
		pd_tick   <= 1'b1;
		in_window <= win;
		@(posedge clk);
		pd_tick <= 1'b0;
		cyc(2);
	endtask : tick

	task automatic pulse_err();
		@(posedge clk);
		phase_err <= 1'b1;
		@(posedge clk);
		phase_err <= 1'b0;
		cyc(2);
	endtask : pulse_err

	task automatic do_reset(input logic [2:0] c);
		@(posedge clk);
		rst_n     <= 1'b0;
		chip_addr <= c;
		cyc(8);
		rst_n <= 1'b1;
		chip_s = c;
		cyc(3);
	endtask : do_reset

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// watchdog sized well above the roughly twenty thousand cycles the tests need
	initial begin
		cyc(40000);
		n_mismatch++;
		summarize();
	end

	initial begin
		rst_n = 1'b0;
		chip_addr = 3'h0;
		ext_vco_sel = 1'b1;
		pd_tick = 1'b0;
		in_window = 1'b0;
		phase_err = 1'b0;
		// codes 6 and 7 need more ticks than the run allows, so they stay unexercised
		targ = '{WIN_CNT_0, WIN_CNT_1, WIN_CNT_2, WIN_CNT_3, WIN_CNT_4, WIN_CNT_5};
		void'($urandom(88206));
		do_reset(3'h0);
		rd(OFS_LKD, RST_LKD);
		rd(OFS_AEN, RST_AEN);
		rd(4'h3, 24'h0);
		note_exp(W_MOD, 24'h1);
		note_exp(W_OE, 24'h1);
		note_exp(W_BIAS, 24'h1);
		note_exp(W_LVL, 24'h0);
		$display("test reset defaults done");
		// fractional writes with reseeding on, then off
		f = 24'($urandom);
		wr(OFS_FRAC, f);
		e_frac++;
		e_seed++;
		note_exp(W_FRAC, f);
		note_exp(W_NF, 24'(e_frac));
		note_exp(W_NS, 24'(e_seed));
		wr(OFS_MOD, RST_MOD & ~24'h000900);
		note_exp(W_MOD, 24'h0);
		f = 24'($urandom);
		wr(OFS_FRAC, f);
		e_frac++;
		note_exp(W_NF, 24'(e_frac));
		note_exp(W_NS, 24'(e_seed));
		wr(OFS_MOD, RST_MOD);
		note_exp(W_MOD, 24'h1);
		$display("test modulator done");
		// lock reached exactly at the selected consecutive count
		foreach (targ[k]) begin
			wr(OFS_LKD, {RST_LKD[23:3], 3'(k)});
			tick(1'b0);
			repeat (targ[k] - 1) tick(1'b1);
			note_exp(W_LCK, 24'h0);
			tick(1'b1);
			note_exp(W_LCK, 24'h1);
		end
		wr(OFS_LKD, {RST_LKD[23:12], 1'b0, RST_LKD[10:3], 3'h2});
		note_exp(W_LCK, 24'h0);
		repeat (5) tick(1'b1);
		note_exp(W_LCK, 24'h0);
		// a miss in mid-run restarts the consecutive count
		wr(OFS_LKD, {RST_LKD[23:3], 3'h0});
		repeat (4) tick(1'b1);
		tick(1'b0);
		repeat (4) tick(1'b1);
		note_exp(W_LCK, 24'h0);
		tick(1'b1);
		note_exp(W_LCK, 24'h1);
		$display("test lock count done");
		// retrain on a written 0-to-1 of the training bit, not on a rewrite of 1
		wr(OFS_LKD, RST_LKD | 24'h100000);
		note_exp(W_TRN, 24'h1);
		tick(1'b1);
		note_exp(W_TRN, 24'h0);
		wr(OFS_LKD, RST_LKD | 24'h100000);
		note_exp(W_TRN, 24'h0);
		wr(OFS_LKD, RST_LKD);
		wr(OFS_LKD, RST_LKD | 24'h100000);
		note_exp(W_TRN, 24'h1);
		tick(1'b1);
		$display("test training done");
		pulse_err();
		note_exp(W_SLIP, 24'h1);
		tick(1'b1);
		note_exp(W_SLIP, 24'h0);
		wr(OFS_LKD, RST_LKD & ~24'h200000);
		pulse_err();
		note_exp(W_SLIP, 24'h0);
		$display("test slip prevention done");
		wr(OFS_AEN, RST_AEN | 24'h400000 | ((REF_MHZ > 200) ? 24'h200000 : 24'h0));
		note_exp(W_LVL, 24'h1);
		note_exp(W_HF, 24'h1);
		@(posedge clk);
		ext_vco_sel <= 1'b0;
		cyc(3);
		note_exp(W_BIAS, 24'h0);
		@(posedge clk);
		ext_vco_sel <= 1'b1;
		wr(OFS_AEN, RST_AEN & ~24'h000400);
		note_exp(W_BIAS, 24'h0);
		wr(OFS_AEN, RST_AEN & ~24'h000020);
		note_exp(W_OE, 24'h0);
		$display("test analog enable done");
		// nonzero chip address on a shared bus
		do_reset(3'h5);
		note_exp(W_OE, 24'h0);
		wr(OFS_SDO_CFG, 24'h000080);
		note_exp(W_OE, 24'h1);
		rd(OFS_LKD, RST_LKD);
		chip_s = 3'h0;
		wr(OFS_AEN, RST_AEN & ~24'h000020);
		chip_s = 3'h5;
		note_exp(W_OE, 24'h1);
		wr(OFS_AEN, RST_AEN & ~24'h000020);
		note_exp(W_OE, 24'h0);
		$display("test output pin done");
		cyc(2);
		summarize();
	end
endmodule : pld_config_regs_bench

// ---- tb/pld_host_model.sv ----
// serial host model that frames register reads and writes toward the slice
`timescale 1ns/10ps
module pld_host_model
	import pld_pkg::*;
(
	output logic      sclk_o,
	output logic      sen_o,
	output logic      sdi_o,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i
);
	logic last_r = 1'b0;
	wire  line_w;

	// a released pin reads as the inverse of its last level, never as a stale copy
	always @(sdo_i, sdo_oe_i) begin
		if (sdo_oe_i === 1'b1) last_r = sdo_i;
	end
	assign line_w = (sdo_oe_i === 1'b1) ? sdo_i : ~last_r;

	initial begin
		sclk_o = 1'b0;
		sen_o  = 1'b0;
		sdi_o  = 1'b0;
	end

	// one 32-bit frame, msb first; link clock idles low outside frames
	task automatic frame(input pld_frame_t f, output logic [23:0] rdata);
		logic [31:0] bits;
		bits  = f;
		rdata = 24'h0;
		// pins move by non-blocking update so an edge-aligned change never races the sampler
		sen_o <= 1'b1;
		#160;
		for (int i = 31; i >= 0; i--) begin
			sdi_o <= bits[i]; // changed while the link clock is low
			#160 sclk_o <= 1'b1;
			// read bit stands until the next fall, so late sampling is safe
			#150 if (i < 24) rdata[i] = line_w;
			#10 sclk_o <= 1'b0;
		end
		#160 sen_o <= 1'b0;
		sdi_o <= ~sdi_o; // released data line does not keep its level
		#320;
	endtask : frame
endmodule : pld_host_model
